// File: verilog/csr_pkg.sv
`default_nettype none
package csr_pkg;
	// special area map
	localparam logic [7:0] ADDR_IND0 = 8'h00;
	localparam logic [7:0] ADDR_PTR0 = 8'h01;
	localparam logic [7:0] ADDR_IND1 = 8'h02;
	localparam logic [7:0] ADDR_PTR1 = 8'h03;
	localparam logic [7:0] ADDR_BANK = 8'h04;
	localparam logic [7:0] ADDR_ACC = 8'h05;
	localparam logic [7:0] ADDR_PCL = 8'h06;
	localparam logic [7:0] ADDR_FLAGS = 8'h0a;
	localparam logic [7:0] ADDR_GP_BASE = 8'h40;
	// field positions
	localparam int BANK_SEL_BIT = 0;
	localparam int FLG_C = 0;
	localparam int FLG_AC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_PDF = 4;
	localparam int FLG_TO = 5;
	localparam logic [7:0] FLG_SW_MASK = 8'h0f;
	// reset values
	localparam logic [7:0] RST_BANK = 8'h00;
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [7:0] RST_PTR = 8'h00;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	// alu operations
	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
		ALU_CPL, ALU_RLC, ALU_RRC
	} csr_alu_op_t;
endpackage
`default_nettype wire

// File: verilog/csr_core.sv
// Operation
// - alu results always land in the accumulator, never in data memory
// - no register-to-register move; memory stores take the accumulator only
// - pcl write jumps; 8-bit value replaces low byte, upper pc bits kept
// - a pcl load inserts one dummy cycle before execution resumes
// - bank select bit 0 picks bank 0 or bank 1
// - direct addressing always reaches bank 0
// - first pointer and its port always reach bank 0
// - second pointer and its port follow the bank select bit
// - resets clear bank select, except watchdog reset in idle or sleep
// - special registers decode the same whatever the bank
// - bank select bits 7..1 read zero; bit 0 read/write, powers up zero
// - flags byte: 5 time-out, 4 power-down, 3 ov, 2 z, 1 ac, 0 c
// - software writes change only flag bits 0 to 3
// - time-out set by watchdog, cleared by power-up, kick or halt
// - power-down set by halt, cleared by power-up or kick
// - overflow is carry into msb differing from carry out
// - zero flag follows whether the result is zero; rotates leave it unchanged
// - nibble carry set on low nibble carry or no borrow
// - carry set on carry out or no borrow; rotates pass through it
// - flags are never saved on call or interrupt entry
// - unused special locations read zero and ignore writes
// - indirect ports redirect via their pointer; self-target reads zero, writes nothing
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module csr_core #(
	parameter int PC_W = 11,
	parameter int GP_DEPTH = 192
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic acc_load,
	input wire logic acc_store,
	input wire logic alu_go,
	input wire csr_pkg::csr_alu_op_t alu_op,
	input wire logic [7:0] alu_operand,
	input wire logic [PC_W-1:0] pc_cur,
	output logic pc_jump,
	output logic [PC_W-1:0] pc_target,
	output logic pc_dummy,
	input wire logic kick_watchdog_instr,
	input wire logic halt_instr,
	input wire logic wdt_timeout,
	input wire logic sys_reset,
	input wire logic wdt_reset_idle,
	output logic [7:0] alu_result_holder,
	output logic [7:0] core_flags,
	output logic bank_select_bit
);
	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync_ff;
	logic rst_s_n;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_s_n = rst_sync_ff[1];

	// ****************************************
	// state
	// ****************************************
	logic [7:0] acc_ff;
	logic [7:0] bank0_pointer_ff;
	logic [7:0] either_bank_pointer_ff;
	logic bank_sel_ff;
	logic [5:0] flags_ff;
	logic [7:0] rdata_ff;
	logic pc_jump_ff;
	logic pc_dummy_ff;
	logic [PC_W-1:0] pc_target_ff;
	logic [7:0] ram [2][GP_DEPTH];

	// resolved location: {null, bank, address}
	function automatic logic [9:0] resolve(input logic [7:0] a, input logic [7:0] p0,
		input logic [7:0] p1, input logic bsel);
		logic [7:0] eff;
		logic bank;
		logic ind;
		eff = a;
		bank = 1'b0;
		ind = 1'b0;
		if (a == csr_pkg::ADDR_IND0)
		begin
			eff = p0;
			ind = 1'b1;
		end
		else if (a == csr_pkg::ADDR_IND1)
		begin
			eff = p1;
			bank = bsel;
			ind = 1'b1;
		end
		resolve = {ind && (eff == csr_pkg::ADDR_IND0 || eff == csr_pkg::ADDR_IND1), bank, eff};
	endfunction

	// {ov, ac, c, sum}
	function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y,
		input logic cin);
		logic [8:0] s;
		logic c7;
		s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
		c7 = x[7] ^ y[7] ^ s[7];
		add8 = {c7 ^ s[8], x[4] ^ y[4] ^ s[4], s[8], s[7:0]};
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	logic [9:0] loc;
	logic loc_null;
	logic loc_bank;
	logic [7:0] loc_addr;
	logic loc_gp;
	logic [7:0] gp_idx;
	logic wr_any;
	logic [7:0] wr_val;
	logic [7:0] rd_val;
	assign loc = resolve(addr, bank0_pointer_ff, either_bank_pointer_ff, bank_sel_ff);
	assign loc_null = loc[9];
	assign loc_bank = loc[8];
	assign loc_addr = loc[7:0];
	assign loc_gp = (loc_addr >= csr_pkg::ADDR_GP_BASE) &&
		(32'(loc_addr - csr_pkg::ADDR_GP_BASE) < GP_DEPTH);
	assign gp_idx = loc_addr - csr_pkg::ADDR_GP_BASE;
	assign wr_any = (wr || acc_store) && !loc_null;
	assign wr_val = wr ? wdata : acc_ff;

	always_comb
	begin
		rd_val = 8'h00;
		if (loc_null)
			rd_val = 8'h00;
		else if (loc_gp)
			rd_val = ram[loc_bank][gp_idx];
		else
			unique case (loc_addr)
				csr_pkg::ADDR_PTR0: rd_val = bank0_pointer_ff;
				csr_pkg::ADDR_PTR1: rd_val = either_bank_pointer_ff;
				csr_pkg::ADDR_BANK: rd_val = {7'h00, bank_sel_ff};
				csr_pkg::ADDR_ACC: rd_val = acc_ff;
				csr_pkg::ADDR_PCL: rd_val = pc_cur[7:0];
				csr_pkg::ADDR_FLAGS: rd_val = {2'h0, flags_ff};
				default: rd_val = 8'h00;
			endcase
	end

	// ****************************************
	// alu
	// ****************************************
	logic [7:0] alu_res;
	logic [3:0] alu_flg;
	logic [3:0] alu_aff;
	logic [10:0] sum;
	always_comb
	begin
		sum = 11'h000;
		alu_res = acc_ff;
		alu_flg = flags_ff[3:0];
		alu_aff = 4'h0;
		unique case (alu_op)
			csr_pkg::ALU_ADD, csr_pkg::ALU_ADC:
			begin
				sum = add8(acc_ff, alu_operand,
					alu_op == csr_pkg::ALU_ADC && flags_ff[csr_pkg::FLG_C]);
				alu_aff = 4'hf;
			end
			csr_pkg::ALU_SUB, csr_pkg::ALU_SBC:
			begin
				sum = add8(acc_ff, ~alu_operand,
					alu_op == csr_pkg::ALU_SUB || flags_ff[csr_pkg::FLG_C]);
				alu_aff = 4'hf;
			end
			csr_pkg::ALU_AND: alu_res = acc_ff & alu_operand;
			csr_pkg::ALU_OR: alu_res = acc_ff | alu_operand;
			csr_pkg::ALU_XOR: alu_res = acc_ff ^ alu_operand;
			csr_pkg::ALU_CPL: alu_res = ~acc_ff;
			csr_pkg::ALU_RLC:
			begin
				alu_res = {acc_ff[6:0], flags_ff[csr_pkg::FLG_C]};
				alu_flg[csr_pkg::FLG_C] = acc_ff[7];
				alu_aff[csr_pkg::FLG_C] = 1'b1;
			end
			csr_pkg::ALU_RRC:
			begin
				alu_res = {flags_ff[csr_pkg::FLG_C], acc_ff[7:1]};
				alu_flg[csr_pkg::FLG_C] = acc_ff[0];
				alu_aff[csr_pkg::FLG_C] = 1'b1;
			end
			default: alu_res = acc_ff;
		endcase
		if (alu_aff[csr_pkg::FLG_OV])
		begin
			alu_res = sum[7:0];
			alu_flg[csr_pkg::FLG_C] = sum[8];
			alu_flg[csr_pkg::FLG_AC] = sum[9];
			alu_flg[csr_pkg::FLG_OV] = sum[10];
		end
		if (alu_op != csr_pkg::ALU_RLC && alu_op != csr_pkg::ALU_RRC)
		begin
			alu_flg[csr_pkg::FLG_Z] = (alu_res == 8'h00);
			alu_aff[csr_pkg::FLG_Z] = 1'b1;
		end
	end

	// ****************************************
	// accumulator
	// ****************************************
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			acc_ff <= csr_pkg::RST_ACC;
		else if (ce)
		begin
			if (alu_go)
				acc_ff <= alu_res;
			else if (acc_load)
				acc_ff <= rd_val;
			else if (wr_any && !loc_gp && loc_addr == csr_pkg::ADDR_ACC)
				acc_ff <= wr_val;
		end
	end

	// ****************************************
	// pointers and bank select
	// ****************************************
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			bank0_pointer_ff <= csr_pkg::RST_PTR;
			either_bank_pointer_ff <= csr_pkg::RST_PTR;
		end
		else if (ce && wr_any && !loc_gp)
		begin
			if (loc_addr == csr_pkg::ADDR_PTR0)
				bank0_pointer_ff <= wr_val;
			if (loc_addr == csr_pkg::ADDR_PTR1)
				either_bank_pointer_ff <= wr_val;
		end
	end

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			bank_sel_ff <= csr_pkg::RST_BANK[csr_pkg::BANK_SEL_BIT];
		else if (ce)
		begin
			if (sys_reset && !wdt_reset_idle)
				bank_sel_ff <= csr_pkg::RST_BANK[csr_pkg::BANK_SEL_BIT];
			else if (wr_any && !loc_gp && loc_addr == csr_pkg::ADDR_BANK)
				bank_sel_ff <= wr_val[csr_pkg::BANK_SEL_BIT];
		end
	end

	// ****************************************
	// data memory
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (ce && wr_any && loc_gp)
			ram[loc_bank][gp_idx] <= wr_val;
	end

	// ****************************************
	// flags
	// ****************************************
	// no save path exists
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			flags_ff <= csr_pkg::RST_FLAGS;
		else if (ce)
		begin
			if (alu_go)
				flags_ff[3:0] <= alu_flg;
			else if (wr_any && !loc_gp && loc_addr == csr_pkg::ADDR_FLAGS)
				flags_ff[3:0] <= wr_val[3:0] & csr_pkg::FLG_SW_MASK[3:0];
			if (wdt_timeout)
				flags_ff[csr_pkg::FLG_TO] <= 1'b1;
			else if (kick_watchdog_instr || halt_instr)
				flags_ff[csr_pkg::FLG_TO] <= 1'b0;
			if (halt_instr)
				flags_ff[csr_pkg::FLG_PDF] <= 1'b1;
			else if (kick_watchdog_instr)
				flags_ff[csr_pkg::FLG_PDF] <= 1'b0;
		end
	end

	// ****************************************
	// read port and pc
	// ****************************************
	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			rdata_ff <= 8'h00;
		else if (ce && rd)
			rdata_ff <= rd_val;
	end

	always_ff @(posedge clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			pc_jump_ff <= 1'b0;
			pc_dummy_ff <= 1'b0;
			pc_target_ff <= '0;
		end
		else if (ce)
		begin
			pc_dummy_ff <= pc_jump_ff;
			pc_jump_ff <= wr_any && !loc_gp && loc_addr == csr_pkg::ADDR_PCL;
			if (wr_any && !loc_gp && loc_addr == csr_pkg::ADDR_PCL)
				pc_target_ff <= {pc_cur[PC_W-1:8], wr_val};
		end
	end

	assign rdata = rdata_ff;
	assign pc_jump = pc_jump_ff;
	assign pc_dummy = pc_dummy_ff;
	assign pc_target = pc_target_ff;
	assign alu_result_holder = acc_ff;
	assign core_flags = {2'h0, flags_ff};
	assign bank_select_bit = bank_sel_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_n);

	AST_BANK_RESET: assert property (ce && sys_reset && !wdt_reset_idle |=> !bank_sel_ff)
		else $error("bank select not cleared by reset");
	AST_BANK_KEEP: assert property (ce && wdt_reset_idle && !wr_any |=> $stable(bank_sel_ff))
		else $error("bank select changed by idle watchdog reset");
	AST_BANK_READ: assert property (ce && rd && addr == csr_pkg::ADDR_BANK
		|=> rdata[7:1] == 7'h00 && rdata[0] == $past(bank_sel_ff))
		else $error("bank select read wrong");
	AST_FLAG_RO: assert property (ce && !wdt_timeout && !halt_instr
		&& !kick_watchdog_instr |=> $stable(flags_ff[5:4]))
		else $error("system flags changed without event");
	AST_TO_SET: assert property (ce && wdt_timeout |=> flags_ff[csr_pkg::FLG_TO])
		else $error("time-out flag not set");
	AST_PDF_SET: assert property (ce && halt_instr
		|=> flags_ff[csr_pkg::FLG_PDF] && (!flags_ff[csr_pkg::FLG_TO] || $past(wdt_timeout)))
		else $error("halt flags wrong");
	AST_ZERO: assert property (ce && alu_go && alu_op == csr_pkg::ALU_XOR
		|=> flags_ff[csr_pkg::FLG_Z] == (acc_ff == 8'h00))
		else $error("zero flag mismatch");
	AST_ADD_CARRY: assert property (ce && alu_go && alu_op == csr_pkg::ALU_ADD
		|=> {flags_ff[csr_pkg::FLG_C], acc_ff} == {1'b0, $past(acc_ff)} + $past(alu_operand))
		else $error("add result or carry wrong");
	AST_PCL_JUMP: assert property (ce && wr && !loc_null && addr == csr_pkg::ADDR_PCL
		|=> pc_jump && pc_target == {$past(pc_cur[PC_W-1:8]), $past(wdata)} ##1 pc_dummy)
		else $error("pcl jump wrong");
	AST_UNUSED: assert property (ce && rd && addr == 8'h3f |=> rdata == 8'h00)
		else $error("unused location read nonzero");

	COV_JUMP: cover property (pc_jump ##1 pc_dummy);
	COV_BANK1: cover property (ce && wr && addr == csr_pkg::ADDR_IND1 && bank_sel_ff);
	COV_TO: cover property (ce && wdt_timeout);
	COV_SUB: cover property (ce && alu_go && alu_op == csr_pkg::ALU_SUB);
endmodule // csr_core
`default_nettype wire

// File: bench/core_special_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module core_special_registers_test;
	localparam int PCW = 11;
	logic clk, rst_n, ce, wr, rd, acc_load, acc_store, alu_go;
	logic [7:0] addr, wdata, rdata, alu_operand, alu_result_holder, core_flags;
	csr_pkg::csr_alu_op_t alu_op;
	logic [PCW-1:0] pc_cur, pc_target;
	logic pc_jump, pc_dummy, bank_select_bit;
	logic kick_watchdog_instr, halt_instr, wdt_timeout, sys_reset, wdt_reset_idle;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;

	csr_core #(.PC_W(PCW)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .acc_load(acc_load),
		.acc_store(acc_store), .alu_go(alu_go), .alu_op(alu_op),
		.alu_operand(alu_operand), .pc_cur(pc_cur), .pc_jump(pc_jump),
		.pc_target(pc_target), .pc_dummy(pc_dummy),
		.kick_watchdog_instr(kick_watchdog_instr), .halt_instr(halt_instr),
		.wdt_timeout(wdt_timeout), .sys_reset(sys_reset),
		.wdt_reset_idle(wdt_reset_idle), .alu_result_holder(alu_result_holder),
		.core_flags(core_flags), .bank_select_bit(bank_select_bit));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************
	// access tasks
	// ****************
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK($sformatf("rdata at %h", a), e, rdata)
	endtask

	task automatic acc_move(input logic ld, input logic st, input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		acc_load <= ld;
		acc_store <= st;
		@(posedge clk);
		acc_load <= 1'b0;
		acc_store <= 1'b0;
		#1;
	endtask

	// order: kick, halt, watchdog time-out, reset, idle qualifier
	task automatic ev(input logic [4:0] v);
		@(posedge clk);
		{kick_watchdog_instr, halt_instr, wdt_timeout, sys_reset, wdt_reset_idle} <= v;
		@(posedge clk);
		{kick_watchdog_instr, halt_instr, wdt_timeout, sys_reset, wdt_reset_idle} <= 5'h00;
		#1;
	endtask

	task automatic alu_chk(input csr_pkg::csr_alu_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic [3:0] pre, input logic [7:0] res,
		input logic [3:0] flg);
		wr_reg(csr_pkg::ADDR_ACC, a);
		wr_reg(csr_pkg::ADDR_FLAGS, {4'h0, pre});
		@(posedge clk);
		alu_op <= op;
		alu_operand <= b;
		alu_go <= 1'b1;
		@(posedge clk);
		alu_go <= 1'b0;
		#1;
		`CHK("accumulator", res, alu_result_holder)
		`CHK("flags", {4'h0, flg}, core_flags)
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// ****************
	// tests
	// ****************
	initial
	begin
		{rst_n, ce, wr, rd, acc_load, acc_store, alu_go} = 7'b0100000;
		{addr, wdata, alu_operand} = 24'h000000;
		alu_op = csr_pkg::ALU_ADD;
		pc_cur = 11'h5a3;
		{kick_watchdog_instr, halt_instr, wdt_timeout, sys_reset, wdt_reset_idle} = 5'h00;
		do_reset();
		`CHK("flags high", 4'h0, core_flags[7:4])
		rd_chk(csr_pkg::ADDR_BANK, 8'h00);
		wr_reg(csr_pkg::ADDR_BANK, 8'hff);
		rd_chk(csr_pkg::ADDR_BANK, 8'h01);
		`CHK("bank", 1'b1, bank_select_bit)
		wr_reg(8'h40, 8'ha5);
		wr_reg(csr_pkg::ADDR_PTR1, 8'h40);
		wr_reg(csr_pkg::ADDR_IND1, 8'h3c);
		rd_chk(8'h40, 8'ha5);
		rd_chk(csr_pkg::ADDR_IND1, 8'h3c);
		wr_reg(csr_pkg::ADDR_PTR0, 8'h40);
		rd_chk(csr_pkg::ADDR_IND0, 8'ha5);
		wr_reg(csr_pkg::ADDR_IND0, 8'h11);
		rd_chk(8'h40, 8'h11);
		wr_reg(csr_pkg::ADDR_PTR1, csr_pkg::ADDR_BANK);
		rd_chk(csr_pkg::ADDR_IND1, 8'h01);
		wr_reg(csr_pkg::ADDR_BANK, 8'h00);
		wr_reg(csr_pkg::ADDR_PTR1, 8'h40);
		rd_chk(csr_pkg::ADDR_IND1, 8'h11);
		wr_reg(csr_pkg::ADDR_PTR0, csr_pkg::ADDR_IND0);
		wr_reg(csr_pkg::ADDR_IND0, 8'h77);
		rd_chk(csr_pkg::ADDR_IND0, 8'h00);
		wr_reg(csr_pkg::ADDR_PTR1, csr_pkg::ADDR_IND1);
		wr_reg(csr_pkg::ADDR_IND1, 8'h66);
		rd_chk(csr_pkg::ADDR_IND1, 8'h00);
		rd_chk(8'h40, 8'h11);
		wr_reg(8'h30, 8'hff);
		rd_chk(8'h30, 8'h00);
		rd_chk(8'h3f, 8'h00);
		acc_move(1'b1, 1'b0, 8'h40);
		`CHK("acc load", 8'h11, alu_result_holder)
		acc_move(1'b0, 1'b1, 8'h41);
		rd_chk(8'h41, 8'h11);
		wr_reg(csr_pkg::ADDR_PCL, 8'h3c);
		`CHK("pc jump", 1'b1, pc_jump)
		`CHK("pc target", 11'h53c, pc_target)
		@(posedge clk);
		#1;
		`CHK("pc dummy", 1'b1, pc_dummy)
		`CHK("pc jump end", 1'b0, pc_jump)
		alu_chk(csr_pkg::ALU_ADD, 8'h7f, 8'h01, 4'h0, 8'h80, 4'ha);
		alu_chk(csr_pkg::ALU_ADD, 8'hff, 8'h01, 4'h0, 8'h00, 4'h7);
		alu_chk(csr_pkg::ALU_ADC, 8'h10, 8'h20, 4'h1, 8'h31, 4'h0);
		alu_chk(csr_pkg::ALU_SUB, 8'h05, 8'h03, 4'h0, 8'h02, 4'h3);
		alu_chk(csr_pkg::ALU_SUB, 8'h03, 8'h05, 4'hf, 8'hfe, 4'h0);
		alu_chk(csr_pkg::ALU_SBC, 8'h05, 8'h05, 4'h1, 8'h00, 4'h7);
		alu_chk(csr_pkg::ALU_AND, 8'hf0, 8'h0f, 4'hb, 8'h00, 4'hf);
		alu_chk(csr_pkg::ALU_OR, 8'h80, 8'h01, 4'h4, 8'h81, 4'h0);
		alu_chk(csr_pkg::ALU_XOR, 8'haa, 8'haa, 4'h0, 8'h00, 4'h4);
		alu_chk(csr_pkg::ALU_CPL, 8'hff, 8'hff, 4'hb, 8'h00, 4'hf);
		alu_chk(csr_pkg::ALU_RLC, 8'h81, 8'h00, 4'h4, 8'h02, 4'h5);
		alu_chk(csr_pkg::ALU_RRC, 8'h02, 8'h00, 4'h1, 8'h81, 4'h0);
		rd_chk(8'h40, 8'h11);
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(csr_pkg::ADDR_ACC, 8'h5a);
		`CHK("acc frozen", 8'h81, alu_result_holder)
		@(posedge clk);
		ce <= 1'b1;
		wr_reg(csr_pkg::ADDR_FLAGS, 8'h00);
		ev(5'b00100);
		`CHK("flags timeout", 8'h20, core_flags)
		ev(5'b01000);
		`CHK("flags halt", 8'h10, core_flags)
		ev(5'b00100);
		wr_reg(csr_pkg::ADDR_FLAGS, 8'h00);
		`CHK("flags ro", 8'h30, core_flags)
		wr_reg(csr_pkg::ADDR_FLAGS, 8'hff);
		`CHK("flags write", 8'h3f, core_flags)
		rd_chk(csr_pkg::ADDR_FLAGS, 8'h3f);
		ev(5'b10000);
		`CHK("flags kick", 8'h0f, core_flags)
		wr_reg(csr_pkg::ADDR_FLAGS, 8'h30);
		`CHK("flags ro set", 8'h00, core_flags)
		wr_reg(csr_pkg::ADDR_BANK, 8'h01);
		ev(5'b00011);
		`CHK("bank idle reset", 1'b1, bank_select_bit)
		ev(5'b00010);
		`CHK("bank reset", 1'b0, bank_select_bit)
		wr_reg(csr_pkg::ADDR_BANK, 8'h01);
		ev(5'b01100);
		do_reset();
		`CHK("bank power up", 1'b0, bank_select_bit)
		`CHK("flags power up", 4'h0, core_flags[7:4])
		wrap_up();
	end
endmodule // core_special_registers_test
`undef CHK
`default_nettype wire
